/* File: hw/dio_pkg.sv */
package dio_pkg;

  // Bus and port widths
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register offsets on the host bus
  localparam logic [ADDR_W-1:0] OFF_PORT_A = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_PORT_B = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_PORT_C = 2'h2;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 2'h3;

  // Reset state: basic mode, every port an input, nothing driven
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h9B;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;

  // Configuration word fields
  localparam int CFG_MODE_SET = 7;
  localparam int CFG_A_MODE_HI = 6;
  localparam int CFG_A_MODE_LO = 5;
  localparam int CFG_A_IN = 4;
  localparam int CFG_CU_IN = 3;
  localparam int CFG_B_MODE = 2;
  localparam int CFG_B_IN = 1;
  localparam int CFG_CL_IN = 0;

  // Single-bit command fields (mode-set bit clear)
  localparam int BSR_SEL_HI = 3;
  localparam int BSR_SEL_LO = 1;
  localparam int BSR_VAL = 0;

  // Status word bit positions
  localparam int ST_A_FULL_N = 7;
  localparam int ST_A_IE = 6;
  localparam int ST_A_IN_FULL = 5;
  localparam int ST_IN_IE = 4;
  localparam int ST_A_REQ = 3;
  localparam int ST_B_IE = 2;
  localparam int ST_B_FULL_N = 1;
  localparam int ST_B_REQ = 0;

  // Third-port lines left free for general use
  localparam logic [DATA_W-1:0] SPARE_A_BASIC = 8'hF8;
  localparam logic [DATA_W-1:0] SPARE_A_STROBED = 8'h30;
  localparam logic [DATA_W-1:0] SPARE_B_BASIC = 8'h07;
  localparam logic [DATA_W-1:0] SPARE_NONE = 8'h00;

  // Upper and lower nibble of the third port
  localparam logic [DATA_W-1:0] NIBBLE_HI = 8'hF0;
  localparam logic [DATA_W-1:0] NIBBLE_LO = 8'h0F;

  // Operating modes of the first port
  typedef enum logic [1:0] {
    A_BASIC,
    A_STROBED,
    A_BIDIR
  } a_mode_t;

endpackage

/* File: hw/sync_bits.sv */
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    s_nxt.meta = async_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sync_out = s_r.stable;
endmodule // sync_bits

/* File: hw/out_flag.sv */
`timescale 1ns/1ps
module out_flag (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic ack_n,
  output logic full_n
);
  typedef struct packed {
    logic full_n;
    logic ack_prev;
  } flag_t;

  flag_t s_r;
  flag_t s_nxt;

  // Host write pulls low, acknowledge edge returns high; write wins
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack_prev = ack_n;
    if (clear)
      s_nxt.full_n = 1'b1;
    else if (load)
      s_nxt.full_n = 1'b0; // R4 R5
    else if (s_r.ack_prev && !ack_n)
      s_nxt.full_n = 1'b1; // R21
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_r <= '{full_n: 1'b1, ack_prev: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign full_n = s_r.full_n;
endmodule // out_flag

/* File: hw/strobed_output_bidir_port.sv */
// Summary of operation
// R1: First port strobed output leaves third-port lines 4 and 5 spare.
// R2: Second port strobed output leaves no spare third-port lines.
// R3: Strobed output: third-port read returns the handshake status word.
// R4: Host write to first port drives its output-full flag low.
// R5: Host write to second port drives its output-full flag low.
// R6: Enables set or cleared by single-bit commands on bits 6 and 2.
// R7: First request high when its enable and output-full flag high.
// R8: Second request high when its enable and output-full flag high.
// R9: Acknowledge levels never appear in the status word.
// R10: Config 0xA0 selects first strobed output, 0x84 second.
// R11: Host polls output-full flag high before writing next byte.
// R12: Bidirectional mode: first port carries input and output transfers.
// R13: Bidirectional only on first port; second stays independently set.
// R14: Bidirectional with second basic: third-port lines 2..0 spare.
// R15: Bidirectional status word layout on third-port read.
// R16: Output enable on bit 6 gates output-full interrupt.
// R17: Input enable on bit 4 gates input-full interrupt.
// R18: Peripheral strobe loads input latch and raises input-full.
// R19: Request high for enabled input-full or enabled output-full.
// R20: Config bit 7 set is a mode word, clear a single-bit command.
// R21: Acknowledge low takes the byte, output-full returns high.
// R22: Bidirectional pins driven only while acknowledge is low.
`timescale 1ns/1ps
module strobed_output_bidir_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dio_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [dio_pkg::DATA_W-1:0] bus_wdata,
  output logic [dio_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [dio_pkg::DATA_W-1:0] pa_in,
  output logic [dio_pkg::DATA_W-1:0] pa_out,
  output logic [dio_pkg::DATA_W-1:0] pa_oe,
  input wire logic [dio_pkg::DATA_W-1:0] pb_in,
  output logic [dio_pkg::DATA_W-1:0] pb_out,
  output logic [dio_pkg::DATA_W-1:0] pb_oe,
  input wire logic [dio_pkg::DATA_W-1:0] pc_in,
  output logic [dio_pkg::DATA_W-1:0] pc_out,
  output logic [dio_pkg::DATA_W-1:0] pc_oe,
  input wire logic first_acknowledge_n,
  input wire logic first_strobe_n,
  input wire logic second_acknowledge_n,
  output logic first_output_full_n,
  output logic first_input_full,
  output logic second_output_full_n,
  output logic first_irq_request,
  output logic second_irq_request
);
  import dio_pkg::*;

  localparam int SYNC_W = 3 * DATA_W + 3;

  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] a_lat;
    logic [DATA_W-1:0] b_lat;
    logic [DATA_W-1:0] in_lat;
    logic [DATA_W-1:0] pc_lat;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] pa_oe;
    logic [DATA_W-1:0] pb_oe;
    logic [DATA_W-1:0] pc_oe;
    logic rvalid;
    logic ibf;
    logic ie_a;
    logic ie_b;
    logic ie_in;
    logic stb_prev;
    logic irq_a;
    logic irq_b;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [DATA_W-1:0] pa_sync;
  logic [DATA_W-1:0] pb_sync;
  logic [DATA_W-1:0] pc_sync;
  logic ack_a;
  logic stb_a;
  logic ack_b;
  logic full_a_n;
  logic full_b_n;
  logic mode_set;
  logic load_a;
  logic load_b;
  a_mode_t a_mode;
  logic b_strobed;

  // Mode of the first port from the configuration word
  function automatic a_mode_t a_mode_of(input logic [DATA_W-1:0] cfg);
    a_mode_t m;
    m = A_BASIC;
    if (cfg[CFG_A_MODE_HI])
      m = A_BIDIR; // R12
    else if (cfg[CFG_A_MODE_LO])
      m = A_STROBED; // R10
    return m;
  endfunction

  // Third-port lines not taken by any handshake
  function automatic logic [DATA_W-1:0] spare_of(
    input logic [DATA_W-1:0] cfg
  );
    logic [DATA_W-1:0] m;
    m = SPARE_NONE;
    case (a_mode_of(cfg))
      A_BASIC:
        m = SPARE_A_BASIC;
      A_STROBED:
        m = SPARE_A_STROBED; // R1
      A_BIDIR:
        m = SPARE_NONE;
      default:
        m = SPARE_NONE;
    endcase
    if (!cfg[CFG_B_MODE])
      m = m | SPARE_B_BASIC; // R14
    return m; // R2
  endfunction

  // Per-line direction of the third port, high for input
  function automatic logic [DATA_W-1:0] pc_dir_in(
    input logic [DATA_W-1:0] cfg
  );
    logic [DATA_W-1:0] d;
    d = BYTE_ZERO;
    if (cfg[CFG_CU_IN])
      d = d | NIBBLE_HI;
    if (cfg[CFG_CL_IN])
      d = d | NIBBLE_LO;
    return d;
  endfunction

  // All pins and handshake inputs come from the peripheral's domain
  sync_bits #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({pa_in, pb_in, pc_in, first_acknowledge_n,
               first_strobe_n, second_acknowledge_n}),
    .sync_out({pa_sync, pb_sync, pc_sync, ack_a, stb_a, ack_b})
  );

  // Host strobes decoded; mode word needs bit 7 set
  always_comb
  begin
    a_mode = a_mode_of(s_r.cfg);
    b_strobed = s_r.cfg[CFG_B_MODE]; // R13
    mode_set = bus_wr && bus_addr == OFF_CONFIG
      && bus_wdata[CFG_MODE_SET]; // R20
    load_a = bus_wr && bus_addr == OFF_PORT_A && a_mode != A_BASIC;
    load_b = bus_wr && bus_addr == OFF_PORT_B && b_strobed;
  end

  // First port output-full, shared by strobed and bidirectional modes
  out_flag u_flag_a (
    .mclk(mclk),
    .rst(rst),
    .clear(mode_set),
    .load(load_a),
    .ack_n(ack_a),
    .full_n(full_a_n)
  );

  // Second port output-full
  out_flag u_flag_b (
    .mclk(mclk),
    .rst(rst),
    .clear(mode_set),
    .load(load_b),
    .ack_n(ack_b),
    .full_n(full_b_n)
  );

  // Register file, handshakes, status word and pin drive
  always_comb
  begin
    logic [DATA_W-1:0] spare;
    logic [DATA_W-1:0] dir_in;
    logic [DATA_W-1:0] spare_val;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] rd_val;
    logic [2:0] sel;
    logic stb_fall;
    spare = spare_of(s_r.cfg);
    dir_in = pc_dir_in(s_r.cfg);
    spare_val = (dir_in & pc_sync) | (~dir_in & s_r.pc_lat);
    status = spare_val & spare;
    rd_val = BYTE_ZERO;
    sel = bus_wdata[BSR_SEL_HI:BSR_SEL_LO];
    stb_fall = s_r.stb_prev && !stb_a;
    s_nxt = s_r;
    s_nxt.stb_prev = stb_a;
    s_nxt.rvalid = bus_rd;

    // Status word: spare lines first, then handshake bits on top
    case (a_mode)
      A_STROBED:
      begin
        status[ST_A_FULL_N] = full_a_n; // R3
        status[ST_A_IE] = s_r.ie_a;
        status[ST_A_REQ] = s_r.irq_a;
      end
      A_BIDIR:
      begin
        status[ST_A_FULL_N] = full_a_n; // R15
        status[ST_A_IE] = s_r.ie_a;
        status[ST_A_IN_FULL] = s_r.ibf;
        status[ST_IN_IE] = s_r.ie_in;
        status[ST_A_REQ] = s_r.irq_a;
      end
      A_BASIC:
        status = status;
      default:
        status = status;
    endcase
    if (b_strobed)
    begin
      status[ST_B_IE] = s_r.ie_b; // R3
      status[ST_B_FULL_N] = full_b_n;
      status[ST_B_REQ] = s_r.irq_b;
    end
    // Acknowledge levels stay off the status word by construction R9

    // Read data, answered one cycle after the read strobe
    case (bus_addr)
      OFF_PORT_A:
      begin
        if (a_mode == A_BIDIR)
          rd_val = s_r.in_lat; // R12
        else if (a_mode == A_BASIC && s_r.cfg[CFG_A_IN])
          rd_val = pa_sync;
        else
          rd_val = s_r.a_lat;
      end
      OFF_PORT_B:
      begin
        if (!b_strobed && s_r.cfg[CFG_B_IN])
          rd_val = pb_sync;
        else
          rd_val = s_r.b_lat;
      end
      OFF_PORT_C:
        rd_val = status;
      OFF_CONFIG:
        rd_val = BYTE_ZERO; // Write-only register
      default:
        rd_val = BYTE_ZERO;
    endcase
    if (bus_rd)
      s_nxt.rdata = rd_val;

    // Host reading the input latch empties it
    if (bus_rd && bus_addr == OFF_PORT_A && a_mode == A_BIDIR)
      s_nxt.ibf = 1'b0;
    // Peripheral strobe loads the latch; a same-cycle read loses
    if (a_mode == A_BIDIR && stb_fall)
    begin
      s_nxt.in_lat = pa_sync; // R18
      s_nxt.ibf = 1'b1; // R18
    end

    // Data port writes
    if (bus_wr && bus_addr == OFF_PORT_A)
      s_nxt.a_lat = bus_wdata;
    if (bus_wr && bus_addr == OFF_PORT_B)
      s_nxt.b_lat = bus_wdata;
    // Direct third-port writes touch only spare lines
    if (bus_wr && bus_addr == OFF_PORT_C)
      s_nxt.pc_lat = (s_r.pc_lat & ~spare) | (bus_wdata & spare);

    // Configuration: mode word or single-bit command
    if (bus_wr && bus_addr == OFF_CONFIG)
    begin
      if (bus_wdata[CFG_MODE_SET])
      begin
        // New mode starts from a clean slate
        s_nxt.cfg = bus_wdata; // R10 R20
        s_nxt.a_lat = BYTE_ZERO;
        s_nxt.b_lat = BYTE_ZERO;
        s_nxt.pc_lat = BYTE_ZERO;
        s_nxt.ibf = 1'b0;
        s_nxt.ie_a = 1'b0;
        s_nxt.ie_b = 1'b0;
        s_nxt.ie_in = 1'b0;
      end
      else if (a_mode != A_BASIC && sel == 3'(ST_A_IE))
        s_nxt.ie_a = bus_wdata[BSR_VAL]; // R6 R16
      else if (a_mode == A_BIDIR && sel == 3'(ST_IN_IE))
        s_nxt.ie_in = bus_wdata[BSR_VAL]; // R17
      else if (b_strobed && sel == 3'(ST_B_IE))
        s_nxt.ie_b = bus_wdata[BSR_VAL]; // R6
      else if (spare[sel])
        s_nxt.pc_lat[sel] = bus_wdata[BSR_VAL];
    end

    // Requests; a high output-full flag means the buffer was taken
    case (a_mode)
      A_STROBED:
        s_nxt.irq_a = s_r.ie_a && full_a_n; // R7
      A_BIDIR:
        s_nxt.irq_a = (s_r.ie_a && full_a_n)
          || (s_r.ie_in && s_r.ibf); // R19
      A_BASIC:
        s_nxt.irq_a = 1'b0;
      default:
        s_nxt.irq_a = 1'b0;
    endcase
    s_nxt.irq_b = b_strobed && s_r.ie_b && full_b_n; // R8

    // First port drive; bidirectional drives only under acknowledge
    case (a_mode)
      A_BASIC:
        s_nxt.pa_oe = s_r.cfg[CFG_A_IN] ? BYTE_ZERO : BYTE_ONES;
      A_STROBED:
        s_nxt.pa_oe = BYTE_ONES;
      A_BIDIR:
        s_nxt.pa_oe = ack_a ? BYTE_ZERO : BYTE_ONES; // R22
      default:
        s_nxt.pa_oe = BYTE_ZERO;
    endcase
    // Second port drive, independent of the first port's mode
    if (b_strobed || !s_r.cfg[CFG_B_IN])
      s_nxt.pb_oe = BYTE_ONES; // R13
    else
      s_nxt.pb_oe = BYTE_ZERO;
    // Spare output lines only; handshake lines have their own pins
    s_nxt.pc_oe = spare & ~dir_in; // R1 R14
  end

  // Single state register; reset leaves every pin undriven
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.cfg <= CFG_RESET;
      s_r.stb_prev <= 1'b0; // Synchroniser resets low; no false edge
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from flip-flops
  assign bus_rdata = s_r.rdata;
  assign bus_rvalid = s_r.rvalid;
  assign pa_out = s_r.a_lat;
  assign pa_oe = s_r.pa_oe;
  assign pb_out = s_r.b_lat;
  assign pb_oe = s_r.pb_oe;
  assign pc_out = s_r.pc_lat;
  assign pc_oe = s_r.pc_oe;
  assign first_output_full_n = full_a_n;
  assign first_input_full = s_r.ibf;
  assign second_output_full_n = full_b_n;
  assign first_irq_request = s_r.irq_a;
  assign second_irq_request = s_r.irq_b;
endmodule // strobed_output_bidir_port

/* File: tb/port_props.sv */
`timescale 1ns/1ps
module port_props
  import dio_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dio_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [dio_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_rvalid,
  input wire logic [dio_pkg::DATA_W-1:0] pa_oe,
  input wire logic [dio_pkg::DATA_W-1:0] pc_oe,
  input wire logic first_acknowledge_n,
  input wire logic first_strobe_n,
  input wire logic first_output_full_n,
  input wire logic first_input_full,
  input wire logic second_output_full_n,
  input wire logic first_irq_request,
  input wire logic second_irq_request
);
  logic [1:0] am_r;
  logic bm_r, iea_r, iei_r, ieb_r;
  logic [2:0] age_r;
  wire cw = bus_wr && bus_addr == OFF_CONFIG;
  wire wa = bus_wr && bus_addr == OFF_PORT_A;
  wire ok = age_r > 3'h1;
  wire a_out = am_r != 2'h0;
  wire bid = am_r == 2'h2;
  wire [DATA_W-1:0] spare = (am_r == 2'h0 ? SPARE_A_BASIC :
    am_r == 2'h1 ? SPARE_A_STROBED : SPARE_NONE) |
    (bm_r ? SPARE_NONE : SPARE_B_BASIC);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Mirror of mode and enables; age guards checks just after a mode word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      am_r <= 2'h0;
      bm_r <= 1'b0;
      iea_r <= 1'b0;
      iei_r <= 1'b0;
      ieb_r <= 1'b0;
      age_r <= 3'h0;
    end
    else if (cw && bus_wdata[CFG_MODE_SET])
    begin
      am_r <= bus_wdata[6] ? 2'h2 : {1'b0, bus_wdata[5]};
      bm_r <= bus_wdata[CFG_B_MODE];
      iea_r <= 1'b0;
      iei_r <= 1'b0;
      ieb_r <= 1'b0;
      age_r <= 3'h0;
    end
    else
    begin
      if (age_r != 3'h7)
        age_r <= age_r + 3'h1;
      if (cw && bus_wdata[3:1] == 3'h6)
        iea_r <= bus_wdata[0];
      if (cw && bus_wdata[3:1] == 3'h4)
        iei_r <= bus_wdata[0];
      if (cw && bus_wdata[3:1] == 3'h2)
        ieb_r <= bus_wdata[0];
    end
  end

  // Relations between host traffic, handshakes and flags
  AST_RD_ANSWER: assert property (bus_rd |=> bus_rvalid)
    else $error("read not answered");
  AST_RD_ONLY: assert property (!bus_rd |=> !bus_rvalid)
    else $error("answer without read");
  AST_A_WR_FULL: assert property (
    a_out && wa |=> !first_output_full_n) else $error("first flag stuck");
  AST_B_WR_FULL: assert property (
    bm_r && bus_wr && bus_addr == OFF_PORT_B |=> !second_output_full_n)
    else $error("second flag stuck");
  AST_A_REQ: assert property (
    ok && a_out |-> first_irq_request == $past(iea_r && first_output_full_n
    || bid && iei_r && first_input_full)) else $error("first request");
  AST_B_REQ: assert property (
    ok && bm_r |-> second_irq_request == $past(ieb_r && second_output_full_n))
    else $error("second request");
  AST_ACK_TAKE: assert property (
    a_out && ok && $fell(first_acknowledge_n) ##0 !wa [*4]
    |-> first_output_full_n) else $error("ack did not take byte");
  AST_IN_FULL: assert property (
    bid && ok && $fell(first_strobe_n) |-> ##[1:3] first_input_full)
    else $error("input full not raised");
  AST_RD_CLR: assert property (
    bid && ok && bus_rd && bus_addr == OFF_PORT_A && $past(first_strobe_n, 2)
    |=> !first_input_full) else $error("input full not cleared");
  AST_BIDIR_DRIVE: assert property (
    bid && age_r == 3'h7 |-> pa_oe == {DATA_W{!$past(first_acknowledge_n, 3)}})
    else $error("bidir drive window");
  AST_STROBED_OE: assert property (
    am_r == 2'h1 && ok |-> pa_oe == BYTE_ONES) else $error("port not driven");
  AST_SPARE: assert property (
    ok |-> (pc_oe & ~spare) == BYTE_ZERO) else $error("non-spare line driven");

  cover property (bid && $fell(first_strobe_n));
  cover property (a_out && $fell(first_acknowledge_n));
  cover property (bm_r && $rose(second_output_full_n));
endmodule // port_props

bind strobed_output_bidir_port port_props port_props_inst (.mclk(mclk),
  .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_wdata(bus_wdata), .bus_rvalid(bus_rvalid), .pa_oe(pa_oe),
  .pc_oe(pc_oe), .first_acknowledge_n(first_acknowledge_n),
  .first_strobe_n(first_strobe_n), .first_output_full_n(first_output_full_n),
  .first_input_full(first_input_full),
  .second_output_full_n(second_output_full_n),
  .first_irq_request(first_irq_request),
  .second_irq_request(second_irq_request));

/* File: tb/port_periph.sv */
`timescale 1ns/1ps
module port_periph
  import dio_pkg::*;
(
  input wire logic mclk,
  input wire logic [dio_pkg::DATA_W-1:0] pa_out,
  input wire logic [dio_pkg::DATA_W-1:0] pa_oe,
  input wire logic [dio_pkg::DATA_W-1:0] pb_out,
  output logic [dio_pkg::DATA_W-1:0] pa_in,
  output logic first_acknowledge_n,
  output logic first_strobe_n,
  output logic second_acknowledge_n
);
  logic [DATA_W-1:0] dat_r = BYTE_ZERO;
  logic drv_r = 1'b0;

  // Handshake lines idle high
  initial
  begin
    first_acknowledge_n = 1'b1;
    first_strobe_n = 1'b1;
    second_acknowledge_n = 1'b1;
  end

  // Released bus shows the inverse of the last byte, never a stale copy
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & (drv_r ? dat_r : ~dat_r));

  // Ack pulse of five cycles takes one byte, then three idle cycles
  task automatic take(input bit sel, output logic [DATA_W-1:0] got);
    @(posedge mclk);
    #2;
    if (sel)
      second_acknowledge_n = 1'b0;
    else
      first_acknowledge_n = 1'b0;
    repeat (5) @(posedge mclk);
    #2;
    got = sel ? pb_out : pa_in;
    first_acknowledge_n = 1'b1;
    second_acknowledge_n = 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // Data set up two cycles ahead of the strobe and held past it
  task automatic send(input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #2;
    dat_r = d;
    drv_r = 1'b1;
    repeat (2) @(posedge mclk);
    #2;
    first_strobe_n = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    first_strobe_n = 1'b1;
    repeat (2) @(posedge mclk);
    #2;
    drv_r = 1'b0;
  endtask
endmodule // port_periph

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import dio_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] bus_addr = OFF_PORT_A;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [DATA_W-1:0] bus_wdata = BYTE_ZERO;
  logic [DATA_W-1:0] bus_rdata, pa_in, pa_out, pa_oe, pb_out, pb_oe;
  logic [DATA_W-1:0] pc_out, pc_oe, got, pg;
  logic ack_a_n, stb_n, ack_b_n, ofa_n, ifa, ofb_n, irq_a, irq_b, bus_rvalid;
  int mismatches = 0;
  int comparisons = 0;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  strobed_output_bidir_port strobed_output_bidir_port_inst (.mclk(mclk),
    .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(~pb_out),
    .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(8'hC3), .pc_out(pc_out),
    .pc_oe(pc_oe), .first_acknowledge_n(ack_a_n), .first_strobe_n(stb_n),
    .second_acknowledge_n(ack_b_n), .first_output_full_n(ofa_n),
    .first_input_full(ifa), .second_output_full_n(ofb_n),
    .first_irq_request(irq_a), .second_irq_request(irq_b));

  port_periph port_periph_inst (.mclk(mclk), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_out(pb_out), .pa_in(pa_in), .first_acknowledge_n(ack_a_n),
    .first_strobe_n(stb_n), .second_acknowledge_n(ack_b_n));

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Host bus cycles, one idle cycle after each
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #2;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge mclk);
    #2;
    bus_wr = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    #2;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge mclk);
    #2;
    bus_rd = 1'b0;
    chk("rvalid", 8'h01, bus_rvalid);
    d = bus_rdata;
  endtask

  task automatic rdc(input string what, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] exp);
    rd(a, got);
    chk(what, exp, got);
  endtask

  // Host waits for the previous byte to be taken, bounded
  task automatic poll(input logic [DATA_W-1:0] mask);
    int n;
    n = 0;
    rd(OFF_PORT_C, got);
    while ((got & mask) == BYTE_ZERO && n < 40)
    begin
      rd(OFF_PORT_C, got);
      n++;
    end
    chk("poll", mask, got & mask);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    conclude;
  end

  // Reset, then first port strobed, second strobed, bidirectional
  initial
  begin
    repeat (2) @(posedge mclk);
    #2;
    rst = 1'b0;
    chk("full_a", 8'h01, ofa_n);
    chk("pa_oe", BYTE_ZERO, pa_oe);
    rdc("cfg", OFF_CONFIG, BYTE_ZERO);
    wr(OFF_CONFIG, 8'hA0);
    wr(OFF_CONFIG, 8'h0D);
    wr(OFF_CONFIG, 8'h09);
    rdc("st", OFF_PORT_C, 8'hD8);
    chk("pc_oe", 8'h37, pc_oe);
    chk("pc_out", 8'h10, pc_out);
    chk("pa_oe", BYTE_ONES, pa_oe);
    wr(OFF_PORT_A, 8'h3C);
    chk("full_a", BYTE_ZERO, ofa_n);
    rdc("st", OFF_PORT_C, 8'h50);
    fork
      port_periph_inst.take(1'b0, pg);
      poll(8'h80);
    join
    chk("pins_a", 8'h3C, pg);
    chk("irq_a", 8'h01, irq_a);
    rdc("st", OFF_PORT_C, 8'hD8);
    wr(OFF_CONFIG, 8'h0C);
    rdc("st", OFF_PORT_C, 8'h90);
    chk("irq_a", BYTE_ZERO, irq_a);
    wr(OFF_CONFIG, 8'h84);
    wr(OFF_CONFIG, 8'h05);
    rdc("st", OFF_PORT_C, 8'h07);
    chk("pc_oe", 8'hF8, pc_oe);
    chk("pb_oe", BYTE_ONES, pb_oe);
    chk("irq_b", 8'h01, irq_b);
    wr(OFF_PORT_B, 8'hA5);
    chk("full_b", BYTE_ZERO, ofb_n);
    rdc("st", OFF_PORT_C, 8'h04);
    fork
      port_periph_inst.take(1'b1, pg);
      poll(8'h02);
    join
    chk("pins_b", 8'hA5, pg);
    rdc("st", OFF_PORT_C, 8'h07);
    wr(OFF_CONFIG, 8'hC0);
    wr(OFF_CONFIG, 8'h09);
    wr(OFF_CONFIG, 8'h0D);
    rdc("st", OFF_PORT_C, 8'hD8);
    chk("pc_oe", 8'h07, pc_oe);
    chk("pa_oe", BYTE_ZERO, pa_oe);
    port_periph_inst.send(8'h96);
    rdc("st", OFF_PORT_C, 8'hF8);
    rdc("in_a", OFF_PORT_A, 8'h96);
    chk("in_full", BYTE_ZERO, ifa);
    wr(OFF_PORT_A, 8'h71);
    wr(OFF_CONFIG, 8'h0C);
    port_periph_inst.send(8'h5A);
    rdc("st", OFF_PORT_C, 8'h38);
    chk("irq_a", 8'h01, irq_a);
    rdc("in_a", OFF_PORT_A, 8'h5A);
    fork
      port_periph_inst.take(1'b0, pg);
      begin
        repeat (5) @(posedge mclk);
        #2;
        chk("pa_oe", BYTE_ONES, pa_oe);
      end
    join
    chk("pins_a", 8'h71, pg);
    rdc("st", OFF_PORT_C, 8'h90);
    chk("pa_oe", BYTE_ZERO, pa_oe);
    wr(OFF_CONFIG, 8'hC4);
    rdc("st", OFF_PORT_C, 8'h82);
    chk("pc_oe", BYTE_ZERO, pc_oe);
    chk("pb_oe", BYTE_ONES, pb_oe);
    wr(OFF_CONFIG, 8'hA9);
    rdc("st", OFF_PORT_C, 8'h83);
    chk("pc_oe", BYTE_ZERO, pc_oe);
    chk("pc_out", BYTE_ZERO, pc_out);
    conclude;
  end
endmodule // tb
